//--- common/smt_regs.svh
`ifndef SMT_REGS_SVH
`define SMT_REGS_SVH

// ----------------------------------------
// Clock and widths
// ----------------------------------------
`define SMT_TCK_PS              25000
`define SMT_NCH                 7
`define SMT_CW                  12

// ----------------------------------------
// Timer channel indices
// ----------------------------------------
`define SMT_CH_ODT              0
`define SMT_CH_WLF              1
`define SMT_CH_WLE              2
`define SMT_CH_GEAR             3
`define SMT_CH_SYNC             4
`define SMT_CH_CMD              5
`define SMT_CH_REF              6

// ----------------------------------------
// Timing figures
// ----------------------------------------
`define SMT_TERM_HOLD_WRITE_LONG_1CK  6
`define SMT_TERM_HOLD_WRITE_LONG_2CK  7
`define SMT_TERM_HOLD_SHORT_1CK       4
`define SMT_TERM_HOLD_SHORT_2CK       5
`define SMT_WLVL_FIRST_STROBE_DELAY   40
`define SMT_WLVL_STROBE_ENABLE_DELAY  25
`define SMT_MRS_UPDATE_DELAY_CK       24
`define SMT_SYNC_EXTRA_CK             4
`define SMT_RESET_EXIT_CMD_DELAY_NS   400
`define SMT_SELFREF_EXIT_DELAY_NS     400
`define SMT_REFRESH_CYCLE_TIME_PS     350000
`define SMT_CAL_MIN_CK                3
`define SMT_CAL_MIN_PS                3748
`define SMT_SPD_ADJ_PERMILLE          974
`define SMT_MIN_RATE_MTS              1600
`define SMT_HOT_ROW_LIMIT             8

`endif

//--- common/smt_pkg.sv
`default_nettype none
`include "smt_regs.svh"

package smt_pkg;

	typedef enum logic [3:0]
	{
		SMT_NOP       = 4'h0,
		SMT_CKE_HIGH  = 4'h1,
		SMT_MRS       = 4'h2,
		SMT_MRS_WLVL  = 4'h3,
		SMT_MRS_GEAR  = 4'h4,
		SMT_GEAR_SYNC = 4'h5,
		SMT_ACT       = 4'h6,
		SMT_WRITE     = 4'h7,
		SMT_READ      = 4'h8,
		SMT_REFRESH   = 4'h9,
		SMT_DQS_EN    = 4'ha,
		SMT_STROBE    = 4'hb,
		SMT_ODT_ON    = 4'hc,
		SMT_ODT_OFF   = 4'hd
	} smt_cmd_e;

	typedef enum logic [1:0]
	{
		SMT_IDLE  = 2'h0,
		SMT_CHECK = 2'h1,
		SMT_HOLD  = 2'h3
	} smt_state_e;

	typedef logic [`SMT_CW-1:0] smt_cnt_t;

	// SPD-based time in ps to clocks: period already whole ps
	function automatic smt_cnt_t smt_ck_spd(input longint ps);
		longint r;
		r = (ps * 1000 / `SMT_TCK_PS + `SMT_SPD_ADJ_PERMILLE) / 1000;
		return smt_cnt_t'(r < 1 ? 1 : r);
	endfunction

	// Other times in ns to clocks, rounded up
	function automatic smt_cnt_t smt_ck_ceil(input longint ns);
		longint r;
		r = (ns * 1000 + `SMT_TCK_PS - 1) / `SMT_TCK_PS;
		return smt_cnt_t'(r < 1 ? 1 : r);
	endfunction

	function automatic smt_cnt_t smt_max(input smt_cnt_t a, input smt_cnt_t b);
		return (a > b) ? a : b;
	endfunction

endpackage

`default_nettype wire

//--- common/smt_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "smt_regs.svh"

interface smt_tmr_if;
	logic [`SMT_NCH-1:0]             load;
	logic [`SMT_NCH-1:0][`SMT_CW-1:0] val;
	logic [`SMT_NCH-1:0]             idle;

	modport ctl  (output load, output val, input idle);
	modport bank (input load, input val, output idle);
endinterface

`default_nettype wire

//--- rtl/smt_tmr_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "smt_regs.svh"

module smt_tmr_bank
	import smt_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	smt_tmr_if.bank   tif
);

	smt_cnt_t cnt_ff [`SMT_NCH];

	// ----------------------------------------
	// Interval counters
	// ----------------------------------------
	// Loading N-1 lets the next command go exactly N edges later
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < `SMT_NCH; i++)
		begin
			if (!rst_n)
				cnt_ff[i] <= '0;
			else if (tif.load[i])
				cnt_ff[i] <= tif.val[i] - smt_cnt_t'(1);
			else if (cnt_ff[i] != '0)
				cnt_ff[i] <= cnt_ff[i] - smt_cnt_t'(1);
		end
	end

	always_comb
	begin
		for (int i = 0; i < `SMT_NCH; i++)
			tif.idle[i] = (cnt_ff[i] == '0);
	end

endmodule

`default_nettype wire

//--- rtl/smt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "smt_regs.svh"

// Summary of operation
// RL1 - Write burst eight: termination high 6/7
// RL2 - Otherwise or chop four: termination high 4/5
// RL3 - First strobe edge 40 clocks after leveling
// RL4 - Drive strobe pair 25 clocks after leveling
// RL5 - Gear-down write waits reset-exit interval after CKE
// RL6 - Gear-down enable waits self-refresh exit interval
// RL7 - Sync pulse after update delay plus four
// RL8 - First command after sync waits update delay
// RL9 - Device starts internal write after latency
// RL10 - Parity with DLL off lengthens refresh
// RL11 - Address latency at least max(3, 3.748ns)
// RL12 - Spread accesses evenly over row addresses (not enforced; only warned via hot_row)
// RL13 - Device accepts properly rounded clock counts
// RL14 - Below 1600 rate use 1600 set
// RL15 - Device drives strobe earlier in two-clock mode
// RL16 - SPD time: divide, add 0.974, truncate
// RL17 - Other time: divide, round up
// RL18 - Flag and hold any too-early command
module smt_ctrl
	import smt_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst_n,
	input  wire logic      req_valid,
	input  wire smt_cmd_e  req_cmd,
	input  wire logic      req_bc4,
	input  wire logic [15:0] req_row,
	input  wire logic      cfg_wpre_2ck,
	input  wire logic      cfg_ca_par,
	input  wire logic      cfg_dll_off,
	input  wire logic [3:0] cfg_par_lat,
	input  wire logic      ddr_dqs_in,
	output logic           req_ready,
	output logic           viol,
	output logic           hot_row,
	output logic           ddr_cke,
	output logic           ddr_cs_n,
	output smt_cmd_e       ddr_cmd,
	output logic           ddr_bc4,
	output logic           ddr_odt,
	output logic           ddr_dqs_out,
	output logic           ddr_dqs_oe,
	output logic [3:0]     cal_lat,
	output logic           wlvl_fb
);

	// ----------------------------------------
	// Derived clock counts
	// ----------------------------------------
	// At 40 MHz the rate is far below 1600, so the 1600 figures hold [RL14]
	localparam smt_cnt_t XPR_CK =
		smt_ck_ceil(`SMT_RESET_EXIT_CMD_DELAY_NS);              // [RL17]
	localparam smt_cnt_t XS_CK =
		smt_ck_ceil(`SMT_SELFREF_EXIT_DELAY_NS);                // [RL17]
	localparam smt_cnt_t GEAR_CK = smt_max(XPR_CK, XS_CK);     // [RL5] [RL6]
	localparam smt_cnt_t RFC_CK =
		smt_ck_spd(`SMT_REFRESH_CYCLE_TIME_PS);                 // [RL16]
	localparam smt_cnt_t CAL_CK = smt_max(smt_cnt_t'(`SMT_CAL_MIN_CK),
		smt_cnt_t'((`SMT_CAL_MIN_PS + `SMT_TCK_PS - 1)
		/ `SMT_TCK_PS));                                       // [RL11]
	localparam smt_cnt_t MOD_CK = smt_cnt_t'(`SMT_MRS_UPDATE_DELAY_CK);

	smt_tmr_if  tif ();
	smt_state_e st_ff;
	smt_cmd_e   cmd_ff;
	logic       bc4_ff;
	logic       req_ready_ff;
	logic       viol_ff;
	logic       cke_ff;
	logic       cs_n_ff;
	smt_cmd_e   ddr_cmd_ff;
	logic       ddr_bc4_ff;
	logic       odt_ff;
	logic       dqs_out_ff;
	logic       dqs_oe_ff;
	logic [3:0] cal_ff;
	logic       dqs_s1_ff;
	logic       dqs_s2_ff;
	logic [15:0] last_row_ff;
	logic [3:0] row_rep_ff;
	logic       hot_row_ff;
	logic       allow;
	logic       issue;
	smt_cnt_t   rfc_val;

	smt_tmr_bank u_tmr
	(
		.clk   (clk),
		.rst_n (rst_n),
		.tif   (tif.bank)
	);

	// ----------------------------------------
	// Interval check
	// ----------------------------------------
	always_comb
	begin
		allow = 1'b1;
		if (cmd_ff != SMT_NOP && cmd_ff != SMT_CKE_HIGH)
			allow = tif.idle[`SMT_CH_CMD] && tif.idle[`SMT_CH_REF]; // [RL8]
		case (cmd_ff)
			SMT_MRS_GEAR:
				allow = allow && tif.idle[`SMT_CH_GEAR];        // [RL5] [RL6]
			SMT_GEAR_SYNC:
				allow = allow && tif.idle[`SMT_CH_SYNC];        // [RL7]
			SMT_STROBE:
				allow = allow && tif.idle[`SMT_CH_WLF];         // [RL3]
			SMT_DQS_EN:
				allow = allow && tif.idle[`SMT_CH_WLE];         // [RL4]
			SMT_ODT_OFF:
				allow = allow && tif.idle[`SMT_CH_ODT];         // [RL1] [RL2]
			default:
				allow = allow;
		endcase
	end

	assign issue = (st_ff == SMT_CHECK || st_ff == SMT_HOLD) && allow;

	// ----------------------------------------
	// Timer loads
	// ----------------------------------------
	// Refresh grows by the parity latency with parity and DLL off
	assign rfc_val = (cfg_ca_par && cfg_dll_off)
		? RFC_CK + smt_cnt_t'(cfg_par_lat) : RFC_CK;          // [RL10]

	always_comb
	begin
		tif.load = '0;
		tif.val  = '0;
		tif.val[`SMT_CH_GEAR] = GEAR_CK;
		tif.val[`SMT_CH_WLF]  = smt_cnt_t'(`SMT_WLVL_FIRST_STROBE_DELAY);
		tif.val[`SMT_CH_WLE]  = smt_cnt_t'(`SMT_WLVL_STROBE_ENABLE_DELAY);
		tif.val[`SMT_CH_SYNC] = MOD_CK + smt_cnt_t'(`SMT_SYNC_EXTRA_CK);
		tif.val[`SMT_CH_CMD]  = MOD_CK;
		tif.val[`SMT_CH_REF]  = rfc_val;
		if (cmd_ff == SMT_WRITE && !bc4_ff)
			tif.val[`SMT_CH_ODT] = cfg_wpre_2ck
				? smt_cnt_t'(`SMT_TERM_HOLD_WRITE_LONG_2CK)
				: smt_cnt_t'(`SMT_TERM_HOLD_WRITE_LONG_1CK);    // [RL1]
		else
			tif.val[`SMT_CH_ODT] = cfg_wpre_2ck
				? smt_cnt_t'(`SMT_TERM_HOLD_SHORT_2CK)
				: smt_cnt_t'(`SMT_TERM_HOLD_SHORT_1CK);         // [RL2]
		if (issue)
		begin
			case (cmd_ff)
				SMT_CKE_HIGH:  tif.load[`SMT_CH_GEAR] = 1'b1;    // [RL5] [RL6]
				SMT_MRS_WLVL:
				begin
					tif.load[`SMT_CH_WLF] = 1'b1;                  // [RL3]
					tif.load[`SMT_CH_WLE] = 1'b1;                  // [RL4]
				end
				SMT_MRS_GEAR:  tif.load[`SMT_CH_SYNC] = 1'b1;    // [RL7]
				SMT_GEAR_SYNC: tif.load[`SMT_CH_CMD] = 1'b1;     // [RL8]
				SMT_REFRESH:   tif.load[`SMT_CH_REF] = 1'b1;     // [RL10]
				SMT_ODT_ON:    tif.load[`SMT_CH_ODT] = 1'b1;     // [RL2]
				SMT_WRITE:     tif.load[`SMT_CH_ODT] = odt_ff;   // [RL1]
				default:       tif.load = '0;
			endcase
		end
	end

	// ----------------------------------------
	// Request handshake and hold
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_ff        <= SMT_IDLE;
			req_ready_ff <= 1'b1;
			cmd_ff       <= SMT_NOP;
			bc4_ff       <= 1'b0;
		end
		else
		begin
			case (st_ff)
				SMT_IDLE:
					if (req_valid && req_ready_ff)
					begin
						st_ff        <= SMT_CHECK;
						req_ready_ff <= 1'b0;
						cmd_ff       <= req_cmd;
						bc4_ff       <= req_bc4;
					end
				SMT_CHECK, SMT_HOLD:
					if (allow)
					begin
						st_ff        <= SMT_IDLE;                    // [RL18]
						req_ready_ff <= 1'b1;
					end
					else
						st_ff <= SMT_HOLD;                          // [RL18]
				default:
					st_ff <= SMT_IDLE;
			endcase
		end
	end

	// Flag only once per held command, at first check
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			viol_ff <= 1'b0;
		else
			viol_ff <= (st_ff == SMT_CHECK) && !allow;          // [RL18]
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cs_n_ff    <= 1'b1;
			ddr_cmd_ff <= SMT_NOP;
			ddr_bc4_ff <= 1'b0;
			dqs_out_ff <= 1'b0;
		end
		else
		begin
			cs_n_ff    <= !(issue && cmd_ff != SMT_NOP);
			ddr_cmd_ff <= issue ? cmd_ff : SMT_NOP;
			ddr_bc4_ff <= issue && bc4_ff;
			dqs_out_ff <= issue && cmd_ff == SMT_STROBE;          // [RL3]
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cke_ff <= 1'b0;
		else if (issue && cmd_ff == SMT_CKE_HIGH)
			cke_ff <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			odt_ff <= 1'b0;
		else if (issue && cmd_ff == SMT_ODT_ON)
			odt_ff <= 1'b1;
		else if (issue && cmd_ff == SMT_ODT_OFF)
			odt_ff <= 1'b0;                                      // [RL1] [RL2]
	end

	// Strobe drive ends with any plain mode write, which leaves leveling
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			dqs_oe_ff <= 1'b0;
		else if (issue && cmd_ff == SMT_DQS_EN)
			dqs_oe_ff <= 1'b1;                                   // [RL4]
		else if (issue && cmd_ff == SMT_MRS)
			dqs_oe_ff <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cal_ff <= 4'h0;
		else
			cal_ff <= CAL_CK[3:0];                               // [RL11]
	end

	// ----------------------------------------
	// Leveling feedback and row activity
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dqs_s1_ff <= 1'b0;
			dqs_s2_ff <= 1'b0;
		end
		else
		begin
			dqs_s1_ff <= ddr_dqs_in;
			dqs_s2_ff <= dqs_s1_ff;
		end
	end

	// Only warns; the caller decides how to spread its rows
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			last_row_ff <= 16'h0;
			row_rep_ff  <= 4'h0;
			hot_row_ff  <= 1'b0;
		end
		else if (req_valid && req_ready_ff && req_cmd == SMT_ACT)
		begin
			last_row_ff <= req_row;
			if (req_row == last_row_ff && row_rep_ff != 4'hf)
				row_rep_ff <= row_rep_ff + 4'h1;
			else if (req_row != last_row_ff)
				row_rep_ff <= 4'h0;
			// Count holds repeats after the first, so limit minus two here
			hot_row_ff <= (req_row == last_row_ff)
				&& (row_rep_ff >= 4'(`SMT_HOT_ROW_LIMIT - 2));      // [RL12]
		end
	end

	assign req_ready   = req_ready_ff;
	assign viol        = viol_ff;
	assign hot_row     = hot_row_ff;
	assign ddr_cke     = cke_ff;
	assign ddr_cs_n    = cs_n_ff;
	assign ddr_cmd     = ddr_cmd_ff;
	assign ddr_bc4     = ddr_bc4_ff;
	assign ddr_odt     = odt_ff;
	assign ddr_dqs_out = dqs_out_ff;
	assign ddr_dqs_oe  = dqs_oe_ff;
	assign cal_lat     = cal_ff;
	assign wlvl_fb     = dqs_s2_ff;

endmodule

`default_nettype wire

//--- bench/smt_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module smt_dev_model
	import smt_pkg::*;
#(
	parameter int WLAT     = 9,
	parameter int RLAT     = 11,
	parameter bit RPRE_2CK = 1'b0
)
(
	input  wire logic     clk,
	input  wire smt_cmd_e ddr_cmd,
	input  wire logic     ddr_dqs_out,
	input  wire logic     ddr_dqs_oe,
	output logic          ddr_dqs_in
);
	// ----
	// Device side
	// ----
	int wr_due = 0;
	int rd_lz  = 0;
	always @(posedge clk)
	begin
		// Internal write starts four clocks after latency
		if (ddr_cmd == SMT_WRITE)
			wr_due <= WLAT + 4;
		else if (wr_due > 0)
			wr_due <= wr_due - 1;
		// Strobe leaves high impedance a clock earlier in two-clock mode
		if (ddr_cmd == SMT_READ)
			rd_lz <= RPRE_2CK ? RLAT - 2 : RLAT - 1;
		else if (rd_lz > 0)
			rd_lz <= rd_lz - 1;
		// Any rounded count is accepted
		// Feedback high only for a strobe edge, so a late sample misses it
		ddr_dqs_in <= ddr_dqs_oe && ddr_dqs_out;
	end
endmodule
`default_nettype wire

//--- bench/smt_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module smt_ctrl_chk
	import smt_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       cfg_wpre_2ck,
	input wire logic       cfg_ca_par,
	input wire logic       cfg_dll_off,
	input wire logic [3:0] cfg_par_lat,
	input wire logic       viol,
	input wire logic       ddr_cs_n,
	input wire smt_cmd_e   ddr_cmd,
	input wire logic       ddr_bc4,
	input wire logic       ddr_odt,
	input wire logic       ddr_dqs_out,
	input wire logic [3:0] cal_lat
);
	// ----
	// Cycles since each cause, saturating
	// ----
	logic [11:0] cnt_ff [6];
	logic        long_ff;
	logic [5:0]  hit;
	logic        busy;
	assign busy = ddr_cmd != SMT_NOP && ddr_cmd != SMT_CKE_HIGH;
	assign hit = {ddr_cmd == SMT_ODT_ON || (ddr_cmd == SMT_WRITE && ddr_odt),
		ddr_cmd == SMT_REFRESH, ddr_cmd == SMT_GEAR_SYNC,
		ddr_cmd == SMT_MRS_GEAR, ddr_cmd == SMT_CKE_HIGH,
		ddr_cmd == SMT_MRS_WLVL};
	always_ff @(posedge clk)
		for (int i = 0; i < 6; i++)
			if (!rst_n)
				cnt_ff[i] <= 12'hfff;
			else if (hit[i])
				cnt_ff[i] <= 12'h001;
			else if (cnt_ff[i] != 12'hfff)
				cnt_ff[i] <= cnt_ff[i] + 12'h001;
	// A write restarts the hold only while termination is on
	always_ff @(posedge clk)
		if (!rst_n)
			long_ff <= 1'b0;
		else if (hit[5])
			long_ff <= ddr_cmd == SMT_WRITE && !ddr_bc4;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_viol_single: assert property (viol |=> !viol)
		else $error("flag longer than one cycle");
	a_cs_cmd_tie: assert property (busy |-> !ddr_cs_n ##1 ddr_cs_n)
		else $error("select does not frame command");
	a_cal_lat_min: assert property ($past(rst_n) |-> cal_lat == 4'h3)
		else $error("address latency wrong");
	a_strobe_wait: assert property (ddr_cmd == SMT_STROBE |->
		ddr_dqs_out && cnt_ff[0] >= 12'd40)
		else $error("strobe edge too early");
	a_dqs_en_wait: assert property (ddr_cmd == SMT_DQS_EN |->
		cnt_ff[0] >= 12'd25)
		else $error("strobe drive too early");
	a_gear_after_cke: assert property (ddr_cmd == SMT_MRS_GEAR |->
		cnt_ff[1] >= 12'd16)
		else $error("gear write too early");
	a_sync_wait: assert property (ddr_cmd == SMT_GEAR_SYNC |->
		cnt_ff[2] >= 12'd28)
		else $error("sync pulse too early");
	a_cmd_after_sync: assert property (busy |-> cnt_ff[3] >= 12'd24)
		else $error("command too soon after sync");
	a_refresh_gap: assert property (busy |-> cnt_ff[4] >= 12'd14 +
		((cfg_ca_par && cfg_dll_off) ? cfg_par_lat : 4'h0))
		else $error("command too soon after refresh");
	a_odt_hold: assert property (ddr_cmd == SMT_ODT_OFF |->
		cnt_ff[5] >= (long_ff ? 12'd6 : 12'd4) + cfg_wpre_2ck)
		else $error("termination dropped too early");
	c_blocked: cover property (viol);
	c_sync: cover property (ddr_cmd == SMT_GEAR_SYNC);
	c_strobe: cover property (ddr_dqs_out);
endmodule
bind smt_ctrl smt_ctrl_chk chk (.clk(clk), .rst_n(rst_n),
	.cfg_wpre_2ck(cfg_wpre_2ck), .cfg_ca_par(cfg_ca_par),
	.cfg_dll_off(cfg_dll_off), .cfg_par_lat(cfg_par_lat), .viol(viol),
	.ddr_cs_n(ddr_cs_n), .ddr_cmd(ddr_cmd), .ddr_bc4(ddr_bc4),
	.ddr_odt(ddr_odt), .ddr_dqs_out(ddr_dqs_out), .cal_lat(cal_lat));
`default_nettype wire

//--- bench/test_sdram_mode_timing_rules.sv
`timescale 1ns/1ps
`default_nettype none
module test_sdram_mode_timing_rules
	import smt_pkg::*;
;
	logic        clk = 0, rst_n = 0, req_valid = 0, req_bc4 = 0;
	logic        cfg_wpre_2ck = 0, cfg_ca_par = 0, cfg_dll_off = 0;
	smt_cmd_e    req_cmd = SMT_NOP;
	logic [15:0] req_row = 16'h0000;
	logic [3:0]  cfg_par_lat = 4'h3;
	logic        req_ready, viol, hot_row, ddr_cke, ddr_cs_n, ddr_bc4;
	logic        ddr_odt, ddr_dqs_out, ddr_dqs_oe, wlvl_fb, ddr_dqs_in;
	smt_cmd_e    ddr_cmd;
	logic [3:0]  cal_lat;
	int          fail_count = 0, check_count = 0, cyc = 0, t_iss = 0;
	logic        saw_v;

	smt_ctrl dut (.*);
	smt_dev_model dev (.*);

	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	// ----
	// Helpers
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string msg);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t ns: %s", $time, msg);
		end
	endtask

	// Request waits for the issue cycle; a blocked one is expected late
	task automatic send(input smt_cmd_e cmd, input logic bc4,
		input logic [15:0] row);
		@(posedge clk);
		req_cmd <= cmd;
		req_bc4 <= bc4;
		req_row <= row;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		saw_v = 1'b0;
		repeat (100)
		begin
			@(posedge clk);
			#1;
			if (viol === 1'b1)
				saw_v = 1'b1;
			if (ddr_cs_n === 1'b0)
				break;
		end
		chk(ddr_cs_n, 1'b0, "command never issued");
		t_iss = cyc;
	endtask

	task automatic after(input int t0, input int mn);
		chk(t_iss - t0 >= mn && t_iss - t0 <= mn + 2, 1'b1, "interval");
		chk(saw_v, 1'b1, "early command not flagged");
	endtask

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		chk({ddr_cke, ddr_cs_n, req_ready, ddr_dqs_oe}, 4'h6, "reset pins");
		chk(cal_lat, 4'h3, "address latency");
		$display("reset test done");
	endtask

	task automatic t_gear();
		int t0;
		send(SMT_CKE_HIGH, 1'b0, 16'h0000);
		chk(ddr_cke, 1'b1, "clock enable low");
		t0 = t_iss;
		send(SMT_MRS_GEAR, 1'b0, 16'h0000);
		after(t0, 16);
		t0 = t_iss;
		send(SMT_GEAR_SYNC, 1'b0, 16'h0000);
		after(t0, 28);
		t0 = t_iss;
		send(SMT_ACT, 1'b0, 16'h0001);
		after(t0, 24);
		$display("gear-down test done");
	endtask

	task automatic t_wlvl();
		int t0;
		send(SMT_MRS_WLVL, 1'b0, 16'h0000);
		t0 = t_iss;
		send(SMT_DQS_EN, 1'b0, 16'h0000);
		after(t0, 25);
		chk(ddr_dqs_oe, 1'b1, "strobe not driven");
		send(SMT_STROBE, 1'b0, 16'h0000);
		after(t0, 40);
		chk(wlvl_fb, 1'b0, "feedback too early");
		repeat (3) @(posedge clk);
		#1;
		chk(wlvl_fb, 1'b1, "feedback missing");
		@(posedge clk);
		#1;
		chk(wlvl_fb, 1'b0, "feedback too long");
		send(SMT_MRS, 1'b0, 16'h0000);
		chk(ddr_dqs_oe, 1'b0, "strobe still driven");
		$display("leveling test done");
	endtask

	task automatic t_odt();
		int t0;
		for (int w = 0; w < 2; w++)
			for (int b = 0; b < 3; b++)
			begin
				@(posedge clk);
				cfg_wpre_2ck <= w[0];
				send(SMT_ODT_ON, 1'b0, 16'h0000);
				if (b < 2)
				begin
					send(SMT_WRITE, b[0], 16'h0000);
					chk(ddr_bc4, b[0], "chop flag");
				end
				t0 = t_iss;
				send(SMT_ODT_OFF, 1'b0, 16'h0000);
				after(t0, (b == 0 ? 6 : 4) + w);
				chk(ddr_odt, 1'b0, "termination still on");
			end
		$display("termination test done");
	endtask

	task automatic t_refresh();
		int t0;
		for (int p = 0; p < 2; p++)
		begin
			@(posedge clk);
			cfg_ca_par <= 1'b1;
			cfg_dll_off <= p[0];
			send(SMT_REFRESH, 1'b0, 16'h0000);
			t0 = t_iss;
			send(SMT_ACT, 1'b0, 16'h0002);
			after(t0, p ? 17 : 14);
		end
		$display("refresh test done");
	endtask

	task automatic t_hot();
		for (int i = 0; i < 9; i++)
		begin
			send(SMT_ACT, 1'b0, i < 8 ? 16'h00a5 : 16'h005a);
			chk(hot_row, i == 7, "hot row flag");
		end
		$display("row spread test done");
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		t_reset();
		t_gear();
		t_wlvl();
		t_odt();
		t_refresh();
		t_hot();
		complete_run();
	end

	// Whole run needs well under 2000 cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		fail_count++;
		complete_run();
	end
endmodule
`default_nettype wire
